// ===== verilog/sls_source_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sls_source_ctrl (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Link to the sink
  sls_link_if.source       link,
  // Protected content permission
  output logic             protect_allow_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic        aw_have;
    logic [3:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [19:0] l_addr;
    logic [7:0]  l_wdata;
    logic        l_we;
    logic        req;
    logic        done;
    logic [7:0]  last;
    logic        prot_ok;
    logic        rc_need;
    logic        test_need;
  } sls_src_st_t;

  sls_src_st_t st_reg;
  sls_src_st_t st_next;
  logic [31:0] stat_word;

  // ------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[sls_pkg::ST_BUSY_B] = st_reg.req;
    stat_word[sls_pkg::ST_DONE_B] = st_reg.done;
    stat_word[sls_pkg::ST_PROT_B] = st_reg.prot_ok;
    stat_word[sls_pkg::ST_RC_B]   = st_reg.rc_need;
    stat_word[sls_pkg::ST_TEST_B] = st_reg.test_need;
    stat_word[sls_pkg::ST_DATA_LSB +: 8] = st_reg.last;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // Capture address and data independently
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Perform a write once both halves are held
    if (st_reg.aw_have && st_reg.w_have) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = sls_pkg::RESP_OKAY;
      case ({st_reg.aw_addr[3:2], 2'b00})
        sls_pkg::HR_ADDR: begin
          if (!st_reg.req) begin
            st_next.l_addr = st_reg.w_data[19:0];
          end
        end
        sls_pkg::HR_WDATA: begin
          if (!st_reg.req && st_reg.w_strb[0]) begin
            st_next.l_wdata = st_reg.w_data[7:0];
          end
        end
        sls_pkg::HR_CTRL: begin
          // A start while busy is dropped; one link access at a time
          if (!st_reg.req && st_reg.w_strb[0] && st_reg.w_data[sls_pkg::CTRL_GO_B]) begin
            st_next.req  = 1'b1;
            st_next.l_we = st_reg.w_data[sls_pkg::CTRL_WR_B];
            st_next.done = 1'b0;
          end
        end
        sls_pkg::HR_STAT: st_next.bresp = sls_pkg::RESP_OKAY;
        default:          st_next.bresp = sls_pkg::RESP_SLVERR;
      endcase
    end

    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = sls_pkg::RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        sls_pkg::HR_ADDR:  st_next.rdata = {12'h000, st_reg.l_addr};
        sls_pkg::HR_WDATA: st_next.rdata = {24'h00_0000, st_reg.l_wdata};
        sls_pkg::HR_CTRL:  st_next.rdata = {30'h0000_0000, st_reg.l_we, st_reg.req};
        sls_pkg::HR_STAT:  st_next.rdata = stat_word;
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = sls_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Link answer ends the access and updates follow-up flags
    if (st_reg.req && link.ack) begin
      st_next.req  = 1'b0;
      st_next.done = 1'b1;
      if (!st_reg.l_we) begin
        st_next.last = link.rdata;
        if (st_reg.l_addr == sls_pkg::OFS_COUNT) begin
          st_next.prot_ok = link.rdata[sls_pkg::PROT_RDY_B];
        end
        if (st_reg.l_addr == sls_pkg::OFS_VECT) begin
          st_next.rc_need   = link.rdata[sls_pkg::VEC_RC_B];
          st_next.test_need = link.rdata[sls_pkg::VEC_TEST_B];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Accept a new half only while no response is pending
  assign s_axi_awready   = ~st_reg.aw_have & ~st_reg.bvalid;
  assign s_axi_wready    = ~st_reg.w_have & ~st_reg.bvalid;
  assign s_axi_bvalid    = st_reg.bvalid;
  assign s_axi_bresp     = st_reg.bresp;
  assign s_axi_arready   = ~st_reg.rvalid;
  assign s_axi_rvalid    = st_reg.rvalid;
  assign s_axi_rdata     = st_reg.rdata;
  assign s_axi_rresp     = st_reg.rresp;
  assign link.req        = st_reg.req;
  assign link.we         = st_reg.l_we;
  assign link.addr       = st_reg.l_addr;
  assign link.wdata      = st_reg.l_wdata;
  assign protect_allow_o = st_reg.prot_ok;

endmodule : sls_source_ctrl
`default_nettype wire

// ===== verilog/sls_pkg.sv
`default_nettype none
package sls_pkg;

  // ------------------------------------------------------------
  // Link register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 20;
  localparam logic [19:0] OFS_COUNT = 20'h00200;
  localparam logic [19:0] OFS_VECT  = 20'h00201;
  localparam logic [19:0] OFS_L01   = 20'h00202;
  localparam logic [19:0] OFS_L23   = 20'h00203;

  // Field positions
  localparam int unsigned CNT_MSB     = 5;
  localparam int unsigned PROT_RDY_B  = 6;
  localparam int unsigned VEC_RC_B    = 0;
  localparam int unsigned VEC_TEST_B  = 1;
  localparam int unsigned VEC_PROT_B  = 2;
  localparam int unsigned VEC_SINK_B  = 6;
  localparam logic [7:0]  VEC_MASK    = 8'h47;
  localparam int unsigned LANE_HI_B   = 4;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [5:0]  CNT_MAX     = 6'h3f;

  // ------------------------------------------------------------
  // Host AXI4-Lite register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [3:0]  HR_ADDR  = 4'h0;
  localparam logic [3:0]  HR_WDATA = 4'h4;
  localparam logic [3:0]  HR_CTRL  = 4'h8;
  localparam logic [3:0]  HR_STAT  = 4'hc;
  localparam int unsigned CTRL_GO_B    = 0;
  localparam int unsigned CTRL_WR_B    = 1;
  localparam int unsigned ST_BUSY_B    = 0;
  localparam int unsigned ST_DONE_B    = 1;
  localparam int unsigned ST_PROT_B    = 2;
  localparam int unsigned ST_RC_B      = 3;
  localparam int unsigned ST_TEST_B    = 4;
  localparam int unsigned ST_DATA_LSB  = 8;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : sls_pkg
`default_nettype wire

// ===== verilog/sls_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sls_link_if;
  // Request from the source, held until ack
  logic        req;
  logic        we;
  logic [19:0] addr;
  logic [7:0]  wdata;
  // Answer from the sink, ack is a one-cycle pulse
  logic        ack;
  logic [7:0]  rdata;

  modport sink (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport source (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface : sls_link_if
`default_nettype wire

// ===== verilog/sls_sink_regs.sv
`timescale 1ns/1ps
`default_nettype none

module sls_sink_regs #(
  parameter int unsigned DS_PORTS   = 2,
  parameter bit          PROT_SYSTEM = 1'b1
) (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  // Link to the source
  sls_link_if.sink                      link,
  // Topology and protection status
  input  wire logic                     is_branch_i,
  input  wire logic                     local_render_i,
  input  wire logic [DS_PORTS*6-1:0]    ds_count_i,
  input  wire logic                     local_prot_cap_i,
  input  wire logic [DS_PORTS-1:0]      ds_prot_ready_i,
  input  wire logic                     auth_done_i,
  // Service events, one-cycle pulses
  input  wire logic                     rc_cmd_pend_i,
  input  wire logic                     auto_test_request_i,
  input  wire logic                     protection_irq_i,
  input  wire logic                     sink_irq_i,
  // Lane flags: {symbol_lock, equalized, clock_recovered} per lane
  input  wire logic [11:0]              lane_flags_i,
  // Register view
  output logic [7:0]                    service_irq_vector_o,
  output logic                          protection_ready_o
);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  // A tree wider than 63 ports could never be reported in the six-bit field,
  // so such a build is refused here rather than clipped silently later
  if (DS_PORTS < 1 || DS_PORTS > 63) begin : g_bad_ports
    $error("DS_PORTS must lie between 1 and 63");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // Everything the block remembers lives in one word, so reset and the
  // register process stay one line each
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic [7:0] vec;
    logic [7:0] cnt;
    logic [7:0] l01;
    logic [7:0] l23;
  } sls_sink_st_t;

  sls_sink_st_t st_reg;
  sls_sink_st_t st_next;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam int unsigned CNT_W     = sls_pkg::CNT_MSB + 1;  // Bits in one count report
  localparam int unsigned LANE_W    = 3;                     // Flags carried per lane
  localparam logic [5:0]  CNT_LOCAL = 6'h01;                 // Weight of a local renderer
  localparam logic [5:0]  CNT_NONE  = 6'h00;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Saturating add, so a deep tree cannot wrap the six-bit field
  // Each step clips, so the order of the ports cannot change the result
  function automatic logic [5:0] sls_sat_add(input logic [5:0] a,
                                             input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    sls_sat_add = s[6] ? sls_pkg::CNT_MAX : s[5:0];
  endfunction : sls_sat_add

  // Pack two lanes of three flags into one status byte
  function automatic logic [7:0] sls_lane_pair(input logic [2:0] lo,
                                               input logic [2:0] hi);
    logic [7:0] b;
    b = sls_pkg::RST_BYTE;
    // Gap bits 3 and 7 keep the cleared start value
    b[LANE_W-1:0] = lo;
    b[sls_pkg::LANE_HI_B +: LANE_W] = hi;
    sls_lane_pair = b;
  endfunction : sls_lane_pair

  // ------------------------------------------------------------
  // Sink count and protection readiness
  // ------------------------------------------------------------
  logic [5:0] count_sum;
  logic       all_ready;

  // Total of local renderer plus, on a branch, every downstream report
  always_comb begin
    count_sum = local_render_i ? CNT_LOCAL : CNT_NONE;
    if (is_branch_i) begin
      for (int i = 0; i < DS_PORTS; i++) begin
        count_sum = sls_sat_add(count_sum, ds_count_i[i*CNT_W +: CNT_W]);
      end
    end
  end

  // Ready only when local is capable, auth is done and, on a branch, all downstream are ready
  always_comb begin
    all_ready = local_prot_cap_i & auth_done_i;
    if (is_branch_i) begin
      all_ready = all_ready & (&ds_prot_ready_i);
    end
  end

  // ------------------------------------------------------------
  // Register next state
  // ------------------------------------------------------------
  logic       hit;
  logic       wr_vec;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;

  always_comb begin
    st_next = st_reg;

    // Status bytes are copies, not live wires: a read answers with the value
    // held one cycle before the request, which keeps rdata off long input paths
    // Snapshot status every cycle; link writes never touch it
    st_next.cnt = sls_pkg::RST_BYTE;
    st_next.cnt[sls_pkg::CNT_MSB:0] = count_sum;
    st_next.cnt[sls_pkg::PROT_RDY_B] = all_ready;
    st_next.l01 = sls_lane_pair(lane_flags_i[2:0], lane_flags_i[5:3]);
    st_next.l23 = sls_lane_pair(lane_flags_i[8:6], lane_flags_i[11:9]);

    // The cycle that shows ack refuses a new take, because the source still
    // holds req there until it has seen the answer
    // A request is taken once; ack is a single pulse
    hit = link.req & ~st_reg.ack;
    st_next.ack = hit;
    wr_vec = hit & link.we & (link.addr == sls_pkg::OFS_VECT);

    // Event sources; protection bit only with a protection system
    set_bits = sls_pkg::RST_BYTE;
    set_bits[sls_pkg::VEC_RC_B]   = rc_cmd_pend_i;
    set_bits[sls_pkg::VEC_TEST_B] = auto_test_request_i;
    set_bits[sls_pkg::VEC_PROT_B] = PROT_SYSTEM & protection_irq_i;
    set_bits[sls_pkg::VEC_SINK_B] = sink_irq_i;
    clr_bits = wr_vec ? link.wdata : sls_pkg::RST_BYTE;

    // A pulse that lands with a clearing write survives: losing an event is
    // worse than a source reading a bit it has already handled
    // Set wins over a clear in the same cycle; zero writes hold
    st_next.vec = ((st_reg.vec & ~clr_bits) | set_bits)
                  & sls_pkg::VEC_MASK;

    // Read data, unmapped addresses read zero
    // A write leaves rdata alone, so the last read byte keeps standing
    if (hit && !link.we) begin
      case (link.addr)
        sls_pkg::OFS_COUNT: st_next.rdata = st_reg.cnt;
        sls_pkg::OFS_VECT:  st_next.rdata = st_reg.vec;
        sls_pkg::OFS_L01:   st_next.rdata = st_reg.l01;
        sls_pkg::OFS_L23:   st_next.rdata = st_reg.l23;
        default:            st_next.rdata = sls_pkg::RST_BYTE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------

  // All state clears to zero, so every value is defined before the first update
  // The status copies refresh on the first edge after release, so a read
  // taken right away still sees inputs that are one cycle old
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every view comes straight from flip-flops, so no output can glitch
  assign link.ack             = st_reg.ack;
  assign link.rdata           = st_reg.rdata;
  assign service_irq_vector_o = st_reg.vec;
  assign protection_ready_o   = st_reg.cnt[sls_pkg::PROT_RDY_B];

endmodule : sls_sink_regs
`default_nettype wire

// ===== tb/sls_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sls_link_properties (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // Link signals
  input wire logic        req,
  input wire logic        we,
  input wire logic [19:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic [7:0]  rdata,
  // Sink register view
  input wire logic [7:0]  service_irq_vector_o,
  input wire logic        protection_ready_o
);
  // ----------------------------------------------------------
  // Link handshake
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // A request is taken only while the previous ack is low
  logic tk;
  assign tk = req && !ack;

  a_ack_after_take: assert property (tk |=> ack) else $error("ack late");
  a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack too long");
  a_ack_needs_req: assert property (!req |=> !ack) else $error("ack without request");
  a_req_held_stable: assert property (tk |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed early");
  a_req_released: assert property (ack |=> !req) else $error("request not dropped");

  // ----------------------------------------------------------
  // Register contents
  // ----------------------------------------------------------
  a_vec_reserved_zero: assert property ((service_irq_vector_o & ~sls_pkg::VEC_MASK) == 8'h00)
    else $error("reserved vector bit set");
  // Only a link write to the vector may drop a bit
  a_vec_bits_sticky: assert property (!(tk && we && addr == sls_pkg::OFS_VECT) |=>
    (service_irq_vector_o & $past(service_irq_vector_o)) == $past(service_irq_vector_o))
    else $error("vector bit lost");
  a_vec_read_data: assert property (tk && !we && addr == sls_pkg::OFS_VECT |=>
    rdata == $past(service_irq_vector_o)) else $error("vector read wrong");
  a_count_ready_bit: assert property (tk && !we && addr == sls_pkg::OFS_COUNT |=>
    rdata[7:6] == {1'b0, $past(protection_ready_o)}) else $error("count read wrong");
  a_lane_gap_zero: assert property (tk && !we &&
    (addr == sls_pkg::OFS_L01 || addr == sls_pkg::OFS_L23) |=> !rdata[3] && !rdata[7])
    else $error("lane gap bit set");

  c_vec_write: cover property (tk && we && addr == sls_pkg::OFS_VECT);
  c_count_read: cover property (tk && !we && addr == sls_pkg::OFS_COUNT);
  c_lane_read: cover property (tk && !we && addr == sls_pkg::OFS_L23);
endmodule : sls_link_properties
`default_nettype wire

// ===== tb/tb_sink_link_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sink_link_status_regs;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [3:0]  awa = 0, ara = 0, evt = 0;
  logic [31:0] wd = 0, st;
  logic        brn = 0, lrn = 0, cap = 0, au = 0;
  logic [11:0] dsc = 0, lf = 0;
  logic [1:0]  dsr = 0;
  logic        awr, wr, bv, arr, rv, pal, prdy;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  logic [7:0]  vec, q, e;
  int          num_errors = 0, samples_checked = 0, cyc = 0, t;

  // ----------------------------------------------------------
  // Clock, parts and checker
  // ----------------------------------------------------------
  always #10 core_clk_i = ~core_clk_i;
  sls_link_if link_if();
  sls_sink_regs #(.DS_PORTS(2), .PROT_SYSTEM(1'b1)) i_sls_sink_regs (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link_if), .is_branch_i(brn),
    .local_render_i(lrn), .ds_count_i(dsc), .local_prot_cap_i(cap), .ds_prot_ready_i(dsr),
    .auth_done_i(au), .rc_cmd_pend_i(evt[0]), .auto_test_request_i(evt[1]),
    .protection_irq_i(evt[2]), .sink_irq_i(evt[3]), .lane_flags_i(lf),
    .service_irq_vector_o(vec), .protection_ready_o(prdy));
  sls_source_ctrl i_sls_source_ctrl (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .link(link_if),
    .protect_allow_o(pal));
  sls_link_properties i_sls_link_properties (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req(link_if.req), .we(link_if.we),
    .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata),
    .service_irq_vector_o(vec), .protection_ready_o(prdy));

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bre <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    chk("bresp", {30'h0, br}, {30'h0, sls_pkg::RESP_OKAY});
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    arv <= 1'b1; ara <= a; rre <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    rre <= 1'b0;
    d = rd;
    chk("rresp", {30'h0, rr}, {30'h0, sls_pkg::RESP_OKAY});
  endtask : axi_rd

  // One link access through the controller; polls until done
  task automatic link_op(input logic [19:0] a, input logic w, input logic [7:0] d);
    axi_wr(sls_pkg::HR_ADDR, {12'h0, a});
    axi_wr(sls_pkg::HR_WDATA, {24'h0, d});
    axi_wr(sls_pkg::HR_CTRL, {30'h0, w, 1'b1});
    // No bound of its own: a link that never answers runs into the hang guard
    do begin
      axi_rd(sls_pkg::HR_STAT, st);
    end while (!(st[sls_pkg::ST_DONE_B] && !st[sls_pkg::ST_BUSY_B]));
    q = st[sls_pkg::ST_DATA_LSB +: 8];
  endtask : link_op

  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    int b[4] = '{0, 1, 1, 1};
    int l[4] = '{1, 1, 0, 0};
    int c[4] = '{9, 5, 40, 5};
    int p[4] = '{0, 3, 3, 1};
    int u[4] = '{1, 1, 0, 1};
    logic [11:0] lp[3] = '{12'h5a3, 12'hfff, 12'h0c6};
    logic [7:0] wc[4] = '{8'h05, 8'h00, 8'h40, 8'hff};
    logic [7:0] wx[4] = '{8'h42, 8'h42, 8'h02, 8'h00};
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    // Count and readiness for plain sink, branches and a saturating sum
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      brn <= b[i][0]; lrn <= l[i][0]; dsc <= {6'(c[i] + 2), 6'(c[i])};
      // Local capability is withdrawn in the first pass only
      cap <= (i != 0); dsr <= 2'(p[i]); au <= u[i][0];
      t = l[i] + (b[i] ? 2 * c[i] + 2 : 0);
      if (t > 63) t = 63;
      e = {1'b0, i != 0 && u[i] && (!b[i] || p[i] == 3), 6'(t)};
      repeat (3) @(posedge core_clk_i);
      link_op(sls_pkg::OFS_COUNT, 1'b0, 8'h00);
      chk("count", {24'h0, q}, {24'h0, e});
      chk("allow", {31'h0, pal}, {31'h0, e[6]});
      chk("ready_pin", {31'h0, prdy}, {31'h0, e[6]});
    end
    link_op(sls_pkg::OFS_COUNT, 1'b1, 8'hff);
    link_op(sls_pkg::OFS_COUNT, 1'b0, 8'h00);
    chk("count_ro", {24'h0, q}, {24'h0, e});
    // Lane flags in both lane registers
    foreach (lp[i]) begin
      @(posedge core_clk_i);
      lf <= lp[i];
      repeat (3) @(posedge core_clk_i);
      link_op(sls_pkg::OFS_L01, 1'b1, 8'h00);
      link_op(sls_pkg::OFS_L01, 1'b0, 8'h00);
      chk("lanes01", {24'h0, q}, {24'h0, 1'b0, lp[i][5:3], 1'b0, lp[i][2:0]});
      link_op(sls_pkg::OFS_L23, 1'b0, 8'h00);
      chk("lanes23", {24'h0, q}, {24'h0, 1'b0, lp[i][11:9], 1'b0, lp[i][8:6]});
    end
    link_op(20'h00204, 1'b0, 8'h00);
    chk("unmapped", {24'h0, q}, 32'h0);
    // All four service events, then write-one-clear steps
    @(posedge core_clk_i);
    evt <= 4'hf;
    @(posedge core_clk_i);
    evt <= 4'h0;
    link_op(sls_pkg::OFS_VECT, 1'b0, 8'h00);
    chk("vector", {24'h0, q}, 32'h47);
    chk("fetch", {30'h0, st[4:3]}, 32'h3);
    chk("vector_pin", {24'h0, vec}, 32'h47);
    foreach (wc[i]) begin
      link_op(sls_pkg::OFS_VECT, 1'b1, wc[i]);
      link_op(sls_pkg::OFS_VECT, 1'b0, 8'h00);
      chk("vector_w1c", {24'h0, q}, {24'h0, wx[i]});
      chk("vector_pin", {24'h0, vec}, {24'h0, wx[i]});
    end
    complete_run();
  end
endmodule : tb_sink_link_status_regs
`default_nettype wire
